// ---- src/tmc_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmc_timer
  import tmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        external_count_pin,
  input  wire logic        crystal_in_pin,
  input  wire logic [1:0]  port_c_direction,
  input  wire logic [1:0]  port_c_out,
  input  wire logic        sysclk_from_crystal,
  input  wire logic        core_low_power,
  output logic             crystal_osc_run,
  output logic      [1:0]  pin_out,
  output logic      [1:0]  pin_oe,
  output logic      [1:0]  port_c_read,
  output logic             irq
);

  logic [7:0]  ctrl_ff;
  logic [15:0] count_ff;
  logic [7:0]  high_buf_ff;
  logic [2:0]  presc_ff;
  logic [1:0]  instr_ff;
  logic        status_ff;
  logic        irq_en_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic        ext_prev_ff;
  logic        ext_edge_ff;
  logic        sysxtl_ff;
  logic [1:0]  pin_lvl;
  logic        ext_src;
  logic        ext_edge;
  logic        src_tick;
  logic        ps_tick;
  logic        count_inc;
  logic        wrap;
  logic        addr_ok;
  logic        wr_low;
  logic        wr_high;
  logic        rd_low;
  logic [7:0]  wbyte;
  logic        nxt_status;

  function automatic logic presc_due(input logic [2:0] cnt, input logic [1:0] sel);
    logic [2:0] mask;
    mask = 3'((4'h1 << sel) - 4'h1);
    return (cnt & mask) == mask;
  endfunction

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin inputs: count pin and crystal input both come from outside

  tmc_pin_sync #(.WIDTH(2)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pin_in   ({crystal_in_pin, external_count_pin}),
    .level_ff (pin_lvl)
  );

  // crystal, when on, drives the count input instead of the pin
  assign ext_src  = ctrl_ff[TMC_BIT_OSC_EN] ? pin_lvl[1] : pin_lvl[0];
  assign ext_edge = ext_src & ~ext_prev_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_prev_ff <= 1'b0;
      ext_edge_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_src;
      ext_edge_ff <= ext_edge;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      instr_ff <= 2'h0;
    end else begin
      instr_ff <= instr_ff + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source and prescaler

  always_comb begin
    if (!ctrl_ff[TMC_BIT_SRC]) begin
      src_tick = instr_ff == TMC_INSTR_LAST;
    // async edges count at once, sync ones one clock later
    end else if (ctrl_ff[TMC_BIT_ASYNC]) begin
      src_tick = ext_edge;
    end else begin
      src_tick = ext_edge_ff;
    end
  end

  // prescaler and counter advance only while running
  assign ps_tick   = src_tick && presc_due(presc_ff, ctrl_ff[TMC_BIT_PS_LO +: 2]);
  assign count_inc = ctrl_ff[TMC_BIT_RUN] && ps_tick;
  assign wrap      = count_inc && count_ff == TMC_CNT_MAX && !wr_low
                     && !(wr_high && !ctrl_ff[TMC_BIT_WIDE]);

  always_ff @(posedge clk) begin
    if (rst) begin
      presc_ff <= 3'h0;
    // only a low-byte write clears the prescaler
    end else if (wr_low) begin
      presc_ff <= 3'h0;
    // prescaler rolls over at the selected ratio
    end else if (ctrl_ff[TMC_BIT_RUN] && src_tick) begin
      presc_ff <= ps_tick ? 3'h0 : presc_ff + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, always OKAY

  assign addr_ok = hsel && hready && (htrans == TMC_HTRANS_NONSEQ || htrans == TMC_HTRANS_SEQ);
  assign rd_low  = addr_ok && !hwrite && is_reg(haddr[7:0], TMC_OFS_CNT_LOW);
  assign wbyte   = hwdata[7:0];
  assign wr_low  = wr_pend_ff && is_reg(wr_addr_ff, TMC_OFS_CNT_LOW);
  assign wr_high = wr_pend_ff && is_reg(wr_addr_ff, TMC_OFS_CNT_HIGH);

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        TMC_OFS_CTRL:     hrdata <= {24'h000000, ctrl_ff};
        TMC_OFS_CNT_LOW:  hrdata <= {24'h000000, count_ff[7:0]};
        // wide mode shows the buffer, never the live byte
        TMC_OFS_CNT_HIGH: hrdata <= {24'h000000,
                                     ctrl_ff[TMC_BIT_WIDE] ? high_buf_ff : count_ff[15:8]};
        TMC_OFS_IRQ_STAT: hrdata <= {31'h00000000, status_ff};
        TMC_OFS_IRQ_EN:   hrdata <= {31'h00000000, irq_en_ff};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  always_ff @(posedge clk) begin
    if (rst) begin
      sysxtl_ff <= 1'b0;
    end else begin
      sysxtl_ff <= sysclk_from_crystal;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= TMC_CTRL_RST;
    end else begin
      // bit 7 stored with the other writable fields
      if (wr_pend_ff && is_reg(wr_addr_ff, TMC_OFS_CTRL)) begin
        ctrl_ff <= (wbyte & TMC_CTRL_WMASK) | (ctrl_ff & ~TMC_CTRL_WMASK);
      end
      // status bit follows the system clock source
      ctrl_ff[TMC_BIT_SYS_XTL] <= sysxtl_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count and high-byte buffer

  always_ff @(posedge clk) begin
    if (rst) begin
      high_buf_ff <= TMC_BYTE_RST;
    end else if (rd_low && ctrl_ff[TMC_BIT_WIDE]) begin
      // low read snapshots the live high byte
      high_buf_ff <= count_ff[15:8];
    end else if (wr_high && ctrl_ff[TMC_BIT_WIDE]) begin
      high_buf_ff <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= {TMC_BYTE_RST, TMC_BYTE_RST};
    end else if (wr_low) begin
      // buffered mode loads all sixteen bits at once
      count_ff <= {ctrl_ff[TMC_BIT_WIDE] ? high_buf_ff : count_ff[15:8], wbyte};
    end else if (wr_high && !ctrl_ff[TMC_BIT_WIDE]) begin
      count_ff[15:8] <= wbyte;
    end else if (count_inc) begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flag and interrupt

  // wrap sets, set wins over a same-cycle clear
  assign nxt_status = (status_ff & ~(wr_pend_ff && is_reg(wr_addr_ff, TMC_OFS_IRQ_CLR)
                                     && wbyte[TMC_BIT_OVF])) | wrap;

  always_ff @(posedge clk) begin
    if (rst) begin
      status_ff <= 1'b0;
      irq_en_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      if (wr_pend_ff && is_reg(wr_addr_ff, TMC_OFS_IRQ_EN)) begin
        irq_en_ff <= wbyte[TMC_BIT_OVF];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= nxt_status && irq_en_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator and pins

  // low-power state does not stop it
  always_ff @(posedge clk) begin
    if (rst) begin
      crystal_osc_run <= 1'b0;
    end else begin
      crystal_osc_run <= ctrl_ff[TMC_BIT_OSC_EN] | (1'b0 & core_low_power);
    end
  end

  // running timer takes both pins as inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe      <= 2'h0;
      pin_out     <= 2'h0;
      port_c_read <= 2'h0;
    end else begin
      pin_out <= port_c_out;
      if (ctrl_ff[TMC_BIT_RUN]) begin
        pin_oe      <= 2'h0;
        port_c_read <= 2'h0;
      end else begin
        pin_oe      <= ~port_c_direction;
        port_c_read <= {pin_lvl[1], pin_lvl[0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_wide_low_read;
    ctrl_ff[TMC_BIT_WIDE] && rd_low;
  endsequence
  sequence s_wide_low_write;
    ctrl_ff[TMC_BIT_WIDE] && wr_low;
  endsequence

  AST_HOLD_STOPPED: assert property (@(posedge clk) disable iff (rst)
    (!ctrl_ff[TMC_BIT_RUN] && !wr_pend_ff) |=> count_ff == $past(count_ff))
    else $error("count moved while stopped");

  AST_INSTR_RATE: assert property (@(posedge clk) disable iff (rst)
    (!ctrl_ff[TMC_BIT_SRC] && src_tick) |=> !src_tick [*3])
    else $error("internal tick faster than one in four");

  AST_PRESC_DIV8: assert property (@(posedge clk) disable iff (rst)
    (ctrl_ff[TMC_BIT_PS_LO +: 2] == TMC_PS_8 && ps_tick) |-> presc_ff == 3'h7)
    else $error("prescale 8 ticked early");

  AST_ASYNC_EDGE: assert property (@(posedge clk) disable iff (rst)
    (ctrl_ff[TMC_BIT_SRC] && ctrl_ff[TMC_BIT_ASYNC]) |-> src_tick == ext_edge)
    else $error("async edge not counted directly");

  AST_SNAPSHOT: assert property (@(posedge clk) disable iff (rst)
    s_wide_low_read |=> high_buf_ff == $past(count_ff[15:8]))
    else $error("high buffer missed snapshot");

  AST_WIDE_LOAD: assert property (@(posedge clk) disable iff (rst)
    s_wide_low_write |=> count_ff == {$past(high_buf_ff), $past(wbyte)})
    else $error("wide write not atomic");

  AST_HIGH_HIDDEN: assert property (@(posedge clk) disable iff (rst)
    (ctrl_ff[TMC_BIT_WIDE] && wr_high && !count_inc) |=> count_ff == $past(count_ff))
    else $error("live high byte written directly");

  AST_PRESC_KEEP: assert property (@(posedge clk) disable iff (rst)
    (wr_high && !src_tick) |=> presc_ff == $past(presc_ff))
    else $error("high write touched prescaler");

  AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (rst)
    wrap |=> status_ff && count_ff == 16'h0000)
    else $error("wrap did not set flag");

  AST_IRQ_MASK: assert property (@(posedge clk) disable iff (rst)
    (!irq_en_ff) |=> !irq)
    else $error("masked request raised");

  AST_PINS_INPUT: assert property (@(posedge clk) disable iff (rst)
    ctrl_ff[TMC_BIT_RUN] |=> pin_oe == 2'h0 && port_c_read == 2'h0)
    else $error("pins driven while running");

  AST_OSC_FOLLOW: assert property (@(posedge clk) disable iff (rst)
    ctrl_ff[TMC_BIT_OSC_EN] |=> crystal_osc_run)
    else $error("oscillator not on");

endmodule
`default_nettype wire

// ---- src/tmc_pkg.sv ----
package tmc_pkg;

  // register byte offsets
  localparam logic [7:0] TMC_OFS_CTRL     = 8'h00;
  localparam logic [7:0] TMC_OFS_CNT_LOW  = 8'h04;
  localparam logic [7:0] TMC_OFS_CNT_HIGH = 8'h08;
  localparam logic [7:0] TMC_OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] TMC_OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] TMC_OFS_IRQ_EN   = 8'h14;

  // control register field positions
  localparam int TMC_BIT_RUN     = 0;
  localparam int TMC_BIT_SRC     = 1;
  localparam int TMC_BIT_ASYNC   = 2;
  localparam int TMC_BIT_OSC_EN  = 3;
  localparam int TMC_BIT_PS_LO   = 4;
  localparam int TMC_BIT_SYS_XTL = 6;
  localparam int TMC_BIT_WIDE    = 7;

  // writable control bits; bit 6 is status only
  localparam logic [7:0] TMC_CTRL_WMASK = 8'hbf;
  localparam logic [7:0] TMC_CTRL_RST   = 8'h00;
  localparam logic [7:0] TMC_BYTE_RST   = 8'h00;
  localparam int         TMC_BIT_OVF    = 0;

  // one instruction cycle is four oscillator periods
  localparam int         TMC_INSTR_DIV  = 4;
  localparam logic [1:0] TMC_INSTR_LAST = 2'(TMC_INSTR_DIV - 1);

  localparam logic [15:0] TMC_CNT_MAX  = 16'hffff;
  localparam logic [1:0]  TMC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  TMC_HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0] {
    TMC_PS_1 = 2'b00,
    TMC_PS_2 = 2'b01,
    TMC_PS_4 = 2'b10,
    TMC_PS_8 = 2'b11
  } tmc_prescale_t;

endpackage

// ---- src/tmc_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_ff
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
    end else begin
      meta_ff <= pin_in;
      s2_ff   <= meta_ff;
      s3_ff   <= s2_ff;
    end
  end

  // a change is taken only once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      level_ff <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          level_ff[i] <= s3_ff[i];
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- verif/tmc_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module tmc_src_model #(
  parameter int HALF    = 6,
  parameter int STARTUP = 40
) (
  input  wire logic clk,
  input  wire logic osc_run,
  output logic      ext_pin,
  output logic      xtal_pin
);
  int age;
  int ph;
  initial begin
    ext_pin = 1'b0;
    xtal_pin = 1'b0;
    age = 0;
    ph = 0;
  end
  ////////////////////////////////////////////////////////////
  // runs only when enabled, slow start
  // no low-power input: the crystal never stops for core sleep
  always @(posedge clk) begin
    if (!osc_run) begin
      age <= 0;
      ph <= 0;
      xtal_pin <= 1'b0;
    end else if (age < STARTUP) begin
      age <= age + 1;
    end else if (ph == HALF - 1) begin
      ph <= 0;
      xtal_pin <= ~xtal_pin;
    end else begin
      ph <= ph + 1;
    end
  end
  ////////////////////////////////////////////////////////////
  // rising edges on the external pin
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk);
      ext_pin <= 1'b1;
      repeat (3) @(posedge clk);
      ext_pin <= 1'b0;
    end
  endtask
  // steady level on the external pin, for port read checks
  task automatic level(input logic v);
    ext_pin <= v;
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tmc_pkg::*;
  localparam logic [7:0] CT = TMC_OFS_CTRL, LO = TMC_OFS_CNT_LOW, HI = TMC_OFS_CNT_HIGH;
  localparam logic [7:0] ST = TMC_OFS_IRQ_STAT, CL = TMC_OFS_IRQ_CLR, EN = TMC_OFS_IRQ_EN;
  typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} tmc_row_t;
  logic        clk, rst, hsel, hwrite, ecp, cip, slp, sys, irq, orun, hrdy, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans, dir, pout, pin_out, pin_oe, pread;
  logic [2:0]  hsize;
  int          bad_count, comparisons;
  tmc_row_t    rows [9] = '{'{CT, 32'hff, 32'hbf}, '{CT, 32'h100, 32'h0},
    '{EN, 32'h1, 32'h1}, '{EN, 32'h0, 32'h0}, '{ST, 32'h1, 32'h0}, '{CL, 32'h1, 32'h0},
    '{HI, 32'ha5, 32'ha5}, '{LO, 32'h5a, 32'h5a}, '{8'h20, 32'hff, 32'h0}};
  logic [7:0]  ec [4] = '{8'h03, 8'h07, 8'h13, 8'h02};
  logic [7:0]  ee [4] = '{8'h0a, 8'h0a, 8'h05, 8'h00};
  logic [1:0]  pd [3] = '{2'h1, 2'h2, 2'h0};

  tmc_timer DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
    .hresp(hresp), .hrdata(hrdata), .external_count_pin(ecp), .crystal_in_pin(cip),
    .port_c_direction(dir), .port_c_out(pout), .sysclk_from_crystal(sys),
    .core_low_power(slp), .crystal_osc_run(orun), .pin_out(pin_out), .pin_oe(pin_oe),
    .port_c_read(pread), .irq(irq));
  tmc_src_model #(.HALF(6), .STARTUP(40)) src (.clk(clk), .osc_run(orun),
    .ext_pin(ecp), .xtal_pin(cip));

  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= TMC_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    r = hrdata;
    chk(32'(hresp), 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, {24'h0, e});
  endtask
  task automatic inr(input logic [31:0] lo, input logic [31:0] hi);
    bus(1'b0, LO, 32'h0);
    chk(32'(r >= lo && r <= hi), 32'h1);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // watchdog well above the roughly 1600 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    give_verdict();
  end

  initial begin
    rst = 1'b1;
    {hsel, hwrite, slp, sys} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    dir = 2'h1;
    pout = 2'h3;
    bad_count = 0;
    comparisons = 0;
    settle(4);
    rst <= 1'b0;
    chk(32'({irq, orun, pin_oe}), 32'h0);
    rdc(CT, 8'h00);
    rdc(LO, 8'h00);
    rdc(HI, 8'h00);
    rdc(ST, 8'h00);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      chk(r, rows[i].e);
    end
    // pins released only while stopped, port reads pins then
    src.level(1'b1);
    foreach (pd[i]) begin
      dir <= pd[i];
      pout <= pd[i] ^ 2'h2;
      settle(6);
      chk(32'({pin_oe, pin_out, pread}), {26'h0, ~pd[i], pd[i] ^ 2'h2, 2'h1});
    end
    wr(CT, 8'h01);
    settle(3);
    chk(32'({pin_oe, pread}), 32'h0);
    wr(CT, 8'h00);
    src.level(1'b0);
    sys <= 1'b1;
    settle(4);
    rdc(CT, 8'h40);
    sys <= 1'b0;
    // internal tick, eight ticks per window
    for (int p = 0; p < 4; p++) begin
      wr(LO, 8'h00);
      wr(HI, 8'h00);
      wr(CT, 8'(p << 4) | 8'h01);
      settle(32 << p);
      wr(CT, 8'h00);
      inr(32'h7, 32'h9);
    end
    // external edges: sync, async, 1:2, stopped
    foreach (ec[i]) begin
      wr(LO, 8'h00);
      wr(CT, ec[i]);
      src.pulses(10);
      settle(8);
      wr(CT, 8'h00);
      rdc(LO, ee[i]);
    end
    wr(CT, 8'h08);
    settle(2);
    chk(32'(orun), 32'h1);
    // start-up delay before relying on it
    settle(60);
    slp <= 1'b1;
    wr(LO, 8'h00);
    wr(CT, 8'h0b);
    settle(240);
    wr(CT, 8'h08);
    inr(32'h13, 32'h15);
    slp <= 1'b0;
    wr(CT, 8'h00);
    settle(2);
    chk(32'(orun), 32'h0);
    wr(HI, 8'h12);
    wr(LO, 8'h34);
    wr(CT, 8'h80);
    wr(HI, 8'h56);
    wr(CT, 8'h00);
    rdc(HI, 8'h12);
    wr(CT, 8'h80);
    wr(LO, 8'h78);
    rdc(LO, 8'h78);
    rdc(HI, 8'h56);
    wr(CT, 8'h00);
    wr(HI, 8'h9a);
    wr(CT, 8'h80);
    wr(HI, 8'h00);
    rdc(HI, 8'h00);
    rdc(LO, 8'h78);
    rdc(HI, 8'h9a);
    // only a low write clears the 1:8 prescaler
    wr(HI, 8'h00);
    wr(LO, 8'h00);
    wr(CT, 8'hb3);
    src.pulses(4);
    wr(HI, 8'h00);
    src.pulses(4);
    settle(8);
    rdc(LO, 8'h01);
    src.pulses(4);
    wr(LO, 8'h00);
    src.pulses(4);
    settle(8);
    rdc(LO, 8'h00);
    wr(CT, 8'h00);
    wr(HI, 8'hff);
    wr(LO, 8'hfe);
    wr(CT, 8'h01);
    settle(40);
    chk(32'(irq), 32'h0);
    rdc(ST, 8'h01);
    rdc(HI, 8'h00);
    inr(32'h3, 32'hff);
    wr(EN, 8'h01);
    settle(2);
    chk(32'(irq), 32'h1);
    wr(CL, 8'h01);
    settle(2);
    chk(32'(irq), 32'h0);
    rdc(ST, 8'h00);
    // mid-run reset returns every field to zero
    wr(EN, 8'h01);
    wr(CT, 8'hbb);
    rst <= 1'b1;
    settle(4);
    rst <= 1'b0;
    chk(32'({irq, orun, pin_oe}), 32'h0);
    rdc(CT, 8'h00);
    rdc(EN, 8'h00);
    rdc(LO, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
